// ---- verilog/burst_sram_consts.vh ----
// constants for the burst sram split port interface
`ifndef BURST_SRAM_CONSTS_VH
`define BURST_SRAM_CONSTS_VH
`define DATA_W 18
`define LANE0_HI 8
`define LANE1_LO 9
`define ADDR_W 20
`define ARRAY_SEL_W 2
`define BURST_LEN 4
`define BEAT_W 2
`define BEAT_LAST 2'h3
`define BEAT_ZERO 2'h0
`define BEAT_ONE 2'h1
`define EDGE_W 3
`define EDGE_ZERO 3'h0
`define EDGE_ONE 3'h1
`define LAT_PLL_EDGES 3'h5
`define LAT_LEGACY_EDGES 3'h2
`define PIPE_W 8
`endif

// ---- verilog/burst_sram_split_port_iface.v ----
// double-rate burst sram core with split read and write ports
`include "burst_sram_consts.vh"
module burst_sram_split_port_iface #(
    parameter DATA_W = `DATA_W,
    parameter ADDR_W = `ADDR_W,
    parameter MEM_DEPTH_W = `ADDR_W + `ARRAY_SEL_W
)(
    input wire clk_i,
    input wire rstn_i,
    input wire k_i,
    input wire k_n_i,
    input wire write_port_select_n_i,
    input wire read_port_select_n_i,
    input wire [1:0] byte_lane_write_select_n_i,
    input wire [ADDR_W-1:0] addr_i,
    input wire [DATA_W-1:0] wdata_i,
    input wire pll_off_n_i,
    output reg [DATA_W-1:0] rdata_o,
    output reg rdata_oe_o,
    output reg output_valid_flag_o,
    output reg echo_clock_out_o,
    output reg echo_clock_out_n_o
);
    // two-stage synchronisers for all pins but clk_i and rstn_i
    reg k_s1_q, k_s2_q, k_prev_q;
    reg kn_s1_q, kn_s2_q, kn_prev_q;
    reg wps_s1_q, wps_s2_q, rps_s1_q, rps_s2_q, pll_off_n_s1_q, pll_off_n_s2_q;
    reg [1:0] bws_s1_q, bws_s2_q;
    reg [ADDR_W-1:0] addr_s1_q, addr_s2_q;
    reg [DATA_W-1:0] wd_s1_q, wd_s2_q;
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            k_s1_q <= 1'b0;
            k_s2_q <= 1'b0;
            k_prev_q <= 1'b0;
            kn_s1_q <= 1'b1;
            kn_s2_q <= 1'b1;
            kn_prev_q <= 1'b1;
            wps_s1_q <= 1'b1;
            wps_s2_q <= 1'b1;
            rps_s1_q <= 1'b1;
            rps_s2_q <= 1'b1;
            pll_off_n_s1_q <= 1'b1;
            pll_off_n_s2_q <= 1'b1;
            bws_s1_q <= 2'h3;
            bws_s2_q <= 2'h3;
            addr_s1_q <= {ADDR_W{1'b0}};
            addr_s2_q <= {ADDR_W{1'b0}};
            wd_s1_q <= {DATA_W{1'b0}};
            wd_s2_q <= {DATA_W{1'b0}};
        end
        else
        begin
            k_s1_q <= k_i;
            k_s2_q <= k_s1_q;
            k_prev_q <= k_s2_q;
            kn_s1_q <= k_n_i;
            kn_s2_q <= kn_s1_q;
            kn_prev_q <= kn_s2_q;
            wps_s1_q <= write_port_select_n_i;
            wps_s2_q <= wps_s1_q;
            rps_s1_q <= read_port_select_n_i;
            rps_s2_q <= rps_s1_q;
            pll_off_n_s1_q <= pll_off_n_i;
            pll_off_n_s2_q <= pll_off_n_s1_q;
            bws_s1_q <= byte_lane_write_select_n_i;
            bws_s2_q <= bws_s1_q;
            addr_s1_q <= addr_i;
            addr_s2_q <= addr_s1_q;
            wd_s1_q <= wdata_i;
            wd_s2_q <= wd_s1_q;
        end
    end

    wire k_rise = k_s2_q & ~k_prev_q;
    wire kn_rise = kn_s2_q & ~kn_prev_q;
    wire any_rise = k_rise | kn_rise;

    // storage: four arrays of one mega-word, flat
    reg [DATA_W-1:0] mem [0:(1<<MEM_DEPTH_W)-1];

    // write port
    reg wr_act_q;
    reg [`BEAT_W-1:0] wr_beat_q;
    reg [ADDR_W-1:0] wr_addr_q;
    wire wr_start = k_rise & ~wps_s2_q & ~wr_act_q;
    wire [MEM_DEPTH_W-1:0] wr_loc = {wr_addr_q, wr_beat_q};
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_act_q <= 1'b0;
            wr_beat_q <= `BEAT_ZERO;
            wr_addr_q <= {ADDR_W{1'b0}};
        end
        else if (wr_start)
        begin
            wr_act_q <= 1'b1;
            wr_beat_q <= `BEAT_ZERO;
            wr_addr_q <= addr_s2_q;
        end
        else if (wr_act_q && any_rise)
        begin
            wr_beat_q <= wr_beat_q + `BEAT_ONE;
            if (wr_beat_q == `BEAT_LAST)
                wr_act_q <= 1'b0;
        end
    end
    // high select at a k rise does not set wr_act_q, so data outside a burst is ignored
    always @(posedge clk_i)
    begin
        if (wr_act_q && any_rise)
        begin
            if (!bws_s2_q[0])
                mem[wr_loc][`LANE0_HI:0] <= wd_s2_q[`LANE0_HI:0];
            if (!bws_s2_q[1])
                mem[wr_loc][DATA_W-1:`LANE1_LO] <= wd_s2_q[DATA_W-1:`LANE1_LO];
        end
    end

    // read port: issue pipeline counts clock edges until launch
    reg rd_issue_q;
    reg [ADDR_W-1:0] rd_addr_q;
    reg [`EDGE_W-1:0] rd_wait_q;
    reg rd_act_q;
    reg [`BEAT_W-1:0] rd_beat_q;
    wire [`EDGE_W-1:0] latency = pll_off_n_s2_q ? `LAT_PLL_EDGES : `LAT_LEGACY_EDGES;
    wire rd_start = k_rise & ~rps_s2_q & ~rd_issue_q;
    wire [MEM_DEPTH_W-1:0] rd_loc = {rd_addr_q, rd_beat_q};
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rd_issue_q <= 1'b0;
            rd_addr_q <= {ADDR_W{1'b0}};
            rd_wait_q <= `EDGE_ZERO;
            rd_act_q <= 1'b0;
            rd_beat_q <= `BEAT_ZERO;
        end
        else
        begin
            if (rd_start)
            begin
                rd_issue_q <= 1'b1;
                rd_addr_q <= addr_s2_q;
                rd_wait_q <= latency;
                rd_beat_q <= `BEAT_ZERO;
            end
            else if (rd_issue_q && any_rise)
            begin
                if (!rd_act_q)
                begin
                    if (rd_wait_q == `EDGE_ONE)
                        rd_act_q <= 1'b1;
                    rd_wait_q <= rd_wait_q - `EDGE_ONE;
                end
                else
                begin
                    rd_beat_q <= rd_beat_q + `BEAT_ONE;
                    if (rd_beat_q == `BEAT_LAST)
                    begin
                        rd_act_q <= 1'b0;
                        rd_issue_q <= 1'b0;
                    end
                end
            end
        end
    end

    // output registers: launch on each clock rise
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_o <= {DATA_W{1'b0}};
            rdata_oe_o <= 1'b0;
            output_valid_flag_o <= 1'b0;
            echo_clock_out_o <= 1'b0;
            echo_clock_out_n_o <= 1'b1;
        end
        else
        begin
            echo_clock_out_o <= k_s2_q;
            echo_clock_out_n_o <= ~k_s2_q;
            if (any_rise)
            begin
                output_valid_flag_o <= rd_act_q;
                if (rd_act_q)
                begin
                    rdata_o <= mem[rd_loc];
                    rdata_oe_o <= 1'b1;
                end
                else if (k_rise)
                    rdata_oe_o <= 1'b0;
            end
        end
    end
endmodule // burst_sram_split_port_iface

// ---- bench/burst_sram_chk.sv ----
// read side and echo clock assertions
module burst_sram_chk (
    input wire clk_i,
    input wire rstn_i,
    input wire read_port_select_n_i,
    input wire rdata_oe_o,
    input wire output_valid_flag_o,
    input wire echo_clock_out_o,
    input wire echo_clock_out_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_echo_pair: assert property (echo_clock_out_n_o == !echo_clock_out_o)
        else $error("echo pair not complementary");
    a_echo_runs: assert property ($rose(echo_clock_out_o) |-> ##[1:8] $fell(echo_clock_out_o))
        else $error("echo clock stalled");
    a_valid_oe: assert property (output_valid_flag_o |-> rdata_oe_o)
        else $error("valid data while tristated");
    a_oe_rise: assert property ($rose(rdata_oe_o) |-> output_valid_flag_o)
        else $error("driver on without data");
    a_burst_min: assert property ($rose(output_valid_flag_o) |-> output_valid_flag_o [*8])
        else $error("burst too short");
    a_burst_end: assert property ($rose(output_valid_flag_o) |-> ##[12:24] !output_valid_flag_o)
        else $error("burst too long");
    a_tristate_after: assert property ($fell(output_valid_flag_o) |-> ##[0:12] !rdata_oe_o)
        else $error("outputs not tristated");
    a_read_latency: assert property ($fell(read_port_select_n_i) && !output_valid_flag_o
        |-> !output_valid_flag_o [*8])
        else $error("read data too early");
    a_reset_quiet: assert property ($rose(rstn_i) |-> !output_valid_flag_o && !rdata_oe_o)
        else $error("outputs active at reset release");
endmodule // burst_sram_chk

// ---- bench/kpair_src.sv ----
// free running complementary input clock pair from the controller
module kpair_src (
    output logic k_o,
    output logic k_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        k_o = 1'b0;
        #7;
        forever #80 k_o = !k_o;
    end
    assign k_n_o = !k_o;
endmodule // kpair_src

// ---- bench/tb_burst_sram_split_port_iface.sv ----
// self-checking bench for the burst sram interface
module tb_burst_sram_split_port_iface;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, wps_n = 1'b1, rps_n = 1'b1, pll_n = 1'b1;
    logic [1:0] bws_n = 2'h3;
    logic [19:0] addr = 20'h0;
    logic [17:0] wdata = 18'h0;
    logic [17:0] rdata;
    logic oe, vld, k, k_n;
    logic [17:0] mem [int];
    int err_total = 0;
    int checked = 0;
    kpair_src u_k (.k_o(k), .k_n_o(k_n));
    burst_sram_split_port_iface uut (.clk_i(clk), .rstn_i(rstn), .k_i(k), .k_n_i(k_n),
        .write_port_select_n_i(wps_n), .read_port_select_n_i(rps_n),
        .byte_lane_write_select_n_i(bws_n), .addr_i(addr), .wdata_i(wdata),
        .pll_off_n_i(pll_n), .rdata_o(rdata), .rdata_oe_o(oe), .output_valid_flag_o(vld),
        .echo_clock_out_o(), .echo_clock_out_n_o());
    initial forever #10 clk = !clk;
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // next pin rise, then past the synchroniser
    task automatic slot();
        @(posedge k or posedge k_n);
        repeat (3) @(posedge clk);
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] ln);
        logic [17:0] d;
        wps_n <= 1'b0;
        addr <= a;
        slot();
        wps_n <= 1'b1;
        addr <= 20'($urandom);
        for (int b = 0; b < 4; b++)
        begin
            d = 18'($urandom);
            wdata <= d;
            bws_n <= ln[2*b +: 2];
            if (!ln[2*b]) mem[{a, 2'(b)}][8:0] = d[8:0];
            if (!ln[2*b+1]) mem[{a, 2'(b)}][17:9] = d[17:9];
            slot();
        end
        wdata <= 18'($urandom);
        slot();
    endtask
    task automatic rd(input logic [19:0] a, input int lat);
        rps_n <= 1'b0;
        addr <= a;
        slot();
        rps_n <= 1'b1;
        addr <= 20'($urandom);
        for (int e = 1; e <= lat + 7; e++)
        begin
            @(posedge k or posedge k_n);
            repeat (4) @(posedge clk);
            if (e > lat && e <= lat + 4)
            begin
                chk(rdata, mem[{a, 2'(e - lat - 1)}]);
                chk({16'h0, oe, vld}, 18'h3);
            end
            else
                chk({17'h0, vld}, 18'h0);
            if (e == lat + 7) chk({17'h0, oe}, 18'h0);
        end
        if (lat[0]) slot();
    endtask
    initial
    begin
        logic [19:0] a;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        void'($urandom(32'hE9C81287));
        @(posedge k_n);
        repeat (3) @(posedge clk);
        for (int m = 0; m < 4; m++)
        begin
            pll_n <= !m[0];
            a = (m == 3) ? 20'hFFFFF : 20'($urandom);
            wr(a, 8'h00);
            wr(a, (m == 0) ? 8'hFF : 8'($urandom));
            rd(a, m[0] ? 2 : 5);
            $display("test %0d done", m);
        end
        tally_and_finish();
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule // tb_burst_sram_split_port_iface
bind burst_sram_split_port_iface burst_sram_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .read_port_select_n_i(read_port_select_n_i), .rdata_oe_o(rdata_oe_o),
    .output_valid_flag_o(output_valid_flag_o), .echo_clock_out_o(echo_clock_out_o),
    .echo_clock_out_n_o(echo_clock_out_n_o));
